// ---- ecp_map.vh ----
// constants of the encoder counter process image: reset values, field positions, timing
// assumes inclusion by ecp_top.v only; definitions only
`ifndef ECP_MAP_VH
`define ECP_MAP_VH

// ==================================================
// reset values of the image
`define ECP_RST_BIT            1'b0
`define ECP_RST_WORD           32'h00000000
`define ECP_RST_TIME           64'h0000000000000000

// ==================================================
// identity fields
`define ECP_PROFILE_NUMBER     16'h1389
`define ECP_DEVTYPE_PROF_LSB   0
`define ECP_DEVTYPE_MOD_LSB    16
`define ECP_REV_VARIANT_LSB    0
`define ECP_REV_DESC_LSB       16
`define ECP_SER_YEAR_LSB       0
`define ECP_SER_WEEK_LSB       8
`define ECP_SER_UPPER          16'h0000
`define ECP_IDENTITY_ENTRIES   8'h04

// ==================================================
// timing
`define ECP_CLK_PERIOD_NS      4
`define ECP_PERIOD_RES_NS      200
`define ECP_PERIOD_SCALE_NS    100
`define ECP_PERIOD_MAX_NS      1600000000
`define ECP_FREQ_WINDOW_US     10000
`define ECP_FREQ_SCALE         100

`endif

// ---- ecp_top.v ----
// encoder counter process image: quadrature counter, latch, frequency, period, timestamp, identity
// assumes encoder pins are asynchronous; master image bits and strobes come from logic on clk
`timescale 1ns/100ps
`include "ecp_map.vh"

module ecp_top #(
  parameter        FREQ_WINDOW_CYC  = `ECP_FREQ_WINDOW_US * 1000 / `ECP_CLK_PERIOD_NS,
  parameter        PERIOD_MAX_CYC   = `ECP_PERIOD_MAX_NS / `ECP_CLK_PERIOD_NS,
  parameter [15:0] MODULE_PROFILE   = 16'h0001, // arbitrary value
  parameter [31:0] VENDOR_VALUE     = 32'h0000abcd, // arbitrary value
  parameter [31:0] PRODUCT_VALUE    = 32'h00001234, // arbitrary value
  parameter [15:0] VARIANT_NUMBER   = 16'h0000, // arbitrary value
  parameter [15:0] DESC_REVISION    = 16'h0001, // arbitrary value
  parameter [7:0]  PROD_YEAR        = 8'h00, // arbitrary value
  parameter [7:0]  PROD_WEEK        = 8'h00 // arbitrary value
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // encoder and gate pins
  input  wire        track_a_pin,
  input  wire        track_b_pin,
  input  wire        reference_pin,
  input  wire        external_gate_pin,
  // fieldbus cycle
  input  wire        cycle_strobe,
  input  wire        distributed_clock_sync,
  input  wire        sync_pulse,
  // output objects written by the master
  input  wire        reference_capture_enable,
  input  wire        gate_rise_capture_enable,
  input  wire        preset_load_command,
  input  wire        gate_fall_capture_enable,
  input  wire [31:0] preset_value,
  // counter reset configuration
  input  wire        reference_reset_enable,
  input  wire        gate_reset_enable,
  // input objects read by the master
  output reg         reference_capture_valid,
  output reg         gate_capture_valid,
  output reg         preset_done,
  output reg         track_a_level,
  output reg         track_b_level,
  output reg         reference_level,
  output reg         external_gate_level,
  output reg         sync_fault_flag,
  output reg         input_update_toggle,
  output reg  [31:0] position_count,
  output reg  [31:0] captured_count,
  output reg  [31:0] measured_frequency,
  output reg  [31:0] measured_period,
  output reg  [63:0] last_change_time,
  // identity objects
  output reg  [31:0] device_type_word,
  output reg  [7:0]  identity_entries,
  output reg  [31:0] vendor_code,
  output reg  [31:0] product_code_word,
  output reg  [31:0] revision_word,
  output reg  [31:0] serial_word
);

  // ==================================================
  // derived constants
  localparam [31:0] FREQ_FACTOR  = `ECP_FREQ_SCALE * 1000000 / `ECP_FREQ_WINDOW_US;
  localparam [7:0]  PERIOD_TICK  = `ECP_PERIOD_RES_NS / `ECP_CLK_PERIOD_NS;
  localparam [31:0] PERIOD_STEP  = `ECP_PERIOD_RES_NS / `ECP_PERIOD_SCALE_NS;
  localparam [31:0] PERIOD_LIMIT = `ECP_PERIOD_MAX_NS / `ECP_PERIOD_SCALE_NS;
  localparam [31:0] WINDOW_LAST  = FREQ_WINDOW_CYC - 1;
  localparam [63:0] TIME_STEP    = `ECP_CLK_PERIOD_NS;

  // ==================================================
  // pin synchronisers: bit 0 a, 1 b, 2 c, 3 gate
  wire [3:0] pin_in;
  reg  [3:0] sync1;
  reg  [3:0] sync2;
  reg  [3:0] sync3;
  reg  [3:0] level;
  reg  [3:0] level_prev;

  assign pin_in = {external_gate_pin, reference_pin, track_b_pin, track_a_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      // a change is taken only once stages two and three agree
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1[gi]      <= 1'b0;
          sync2[gi]      <= 1'b0;
          sync3[gi]      <= 1'b0;
          level[gi]      <= 1'b0;
          level_prev[gi] <= 1'b0;
        end else begin
          sync1[gi]      <= pin_in[gi];
          sync2[gi]      <= sync1[gi];
          sync3[gi]      <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            level[gi] <= sync3[gi];
          end
          level_prev[gi] <= level[gi];
        end
      end
    end
  endgenerate

  wire a_rise    = level[0] & ~level_prev[0];
  wire c_rise    = level[2] & ~level_prev[2];
  wire gate_rise = level[3] & ~level_prev[3];
  wire gate_fall = ~level[3] & level_prev[3];

  // ==================================================
  // quadrature decode
  wire a_chg   = level[0] ^ level_prev[0];
  wire b_chg   = level[1] ^ level_prev[1];
  wire step    = a_chg ^ b_chg; // both tracks moving at once is an illegal jump, dropped
  wire step_up = level[0] ^ level_prev[1];

  // ==================================================
  // master command edges
  reg cmd_load_prev;
  reg ref_en_prev;
  reg rise_en_prev;
  reg fall_en_prev;

  wire load_req  = preset_load_command & ~cmd_load_prev;
  wire ref_arm   = reference_capture_enable & ~ref_en_prev;
  wire rise_arm  = gate_rise_capture_enable & ~rise_en_prev;
  wire fall_arm  = gate_fall_capture_enable & ~fall_en_prev;

  // both reset sources at once is unsupported, so neither acts then
  wire reset_ok  = ~(reference_reset_enable & gate_reset_enable);
  wire cnt_clear = reset_ok & ((reference_reset_enable & c_rise) | (gate_reset_enable & gate_rise));

  // ==================================================
  // counter
  reg  [31:0] count;
  reg  [31:0] next_count;
  reg  [63:0] time_ns;
  reg  [63:0] stamp;

  always @* begin
    next_count = count;
    if (load_req) begin
      next_count = preset_value;
    end else if (cnt_clear) begin
      next_count = `ECP_RST_WORD;
    end else if (step) begin
      next_count = step_up ? count + 32'h00000001 : count - 32'h00000001;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count         <= `ECP_RST_WORD;
      time_ns       <= `ECP_RST_TIME;
      stamp         <= `ECP_RST_TIME;
      cmd_load_prev <= 1'b0;
      preset_done   <= `ECP_RST_BIT;
    end else begin
      count         <= next_count;
      time_ns       <= time_ns + TIME_STEP;
      cmd_load_prev <= preset_load_command;
      if (next_count != count) begin
        stamp <= time_ns;
      end
      // load only happens with the command high, so the set never meets the clear
      if (load_req) begin
        preset_done <= 1'b1;
      end else if (!preset_load_command) begin
        preset_done <= 1'b0;
      end
    end
  end

  // ==================================================
  // latch unit
  reg ref_armed;
  reg rise_armed;
  reg fall_armed;
  reg [31:0] latch_val;

  wire ref_hit  = ref_armed & c_rise;
  wire ext_hit  = (rise_armed & gate_rise) | (fall_armed & gate_fall);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_en_prev             <= 1'b0;
      rise_en_prev            <= 1'b0;
      fall_en_prev            <= 1'b0;
      ref_armed               <= 1'b0;
      rise_armed              <= 1'b0;
      fall_armed              <= 1'b0;
      latch_val               <= `ECP_RST_WORD;
      reference_capture_valid <= `ECP_RST_BIT;
      gate_capture_valid      <= `ECP_RST_BIT;
    end else begin
      ref_en_prev  <= reference_capture_enable;
      rise_en_prev <= gate_rise_capture_enable;
      fall_en_prev <= gate_fall_capture_enable;
      // one capture per arming: the enable must drop and rise again
      if (!reference_capture_enable) begin
        ref_armed <= 1'b0;
      end else if (ref_arm) begin
        ref_armed <= 1'b1;
      end else if (ref_hit) begin
        ref_armed <= 1'b0;
      end
      if (!gate_rise_capture_enable) begin
        rise_armed <= 1'b0;
      end else if (rise_arm) begin
        rise_armed <= 1'b1;
      end else if (ext_hit) begin
        rise_armed <= 1'b0;
      end
      if (!gate_fall_capture_enable) begin
        fall_armed <= 1'b0;
      end else if (fall_arm) begin
        fall_armed <= 1'b1;
      end else if (ext_hit) begin
        fall_armed <= 1'b0;
      end
      // the reference event wins when both land in one cycle
      if (ref_hit) begin
        latch_val <= count;
      end else if (ext_hit) begin
        latch_val <= count;
      end
      if (ref_hit) begin
        reference_capture_valid <= 1'b1;
      end else if (!reference_capture_enable) begin
        reference_capture_valid <= 1'b0;
      end
      if (ext_hit) begin
        gate_capture_valid <= 1'b1;
      end else if (!gate_rise_capture_enable && !gate_fall_capture_enable) begin
        gate_capture_valid <= 1'b0;
      end
    end
  end

  // ==================================================
  // frequency: track A rising edges in a fixed window
  reg  [31:0] win_cnt;
  reg  [31:0] edge_cnt;
  reg  [31:0] freq_val;
  wire [63:0] freq_prod = edge_cnt * FREQ_FACTOR;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt  <= `ECP_RST_WORD;
      edge_cnt <= `ECP_RST_WORD;
      freq_val <= `ECP_RST_WORD;
    end else if (win_cnt == WINDOW_LAST) begin
      win_cnt  <= `ECP_RST_WORD;
      edge_cnt <= {31'h00000000, a_rise};
      freq_val <= freq_prod[31:0];
    end else begin
      win_cnt <= win_cnt + 32'h00000001;
      if (a_rise) begin
        edge_cnt <= edge_cnt + 32'h00000001;
      end
    end
  end

  // ==================================================
  // period: resolution ticks between track A rising edges
  reg  [7:0]  tick_cnt;
  reg  [31:0] per_acc;
  reg  [31:0] per_val;
  wire        tick = (tick_cnt == PERIOD_TICK - 8'h01);

  // beyond the longest measurable period the axis is taken as stopped and reads zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 8'h00;
      per_acc  <= `ECP_RST_WORD;
      per_val  <= `ECP_RST_WORD;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      if (a_rise) begin
        // a tick landing on the closing edge belongs to the period it closes, else one step is lost
        per_val <= tick ? per_acc + PERIOD_STEP : per_acc;
        per_acc <= `ECP_RST_WORD;
      end else if (per_acc >= PERIOD_LIMIT) begin
        per_val <= `ECP_RST_WORD;
      end else if (tick) begin
        per_acc <= per_acc + PERIOD_STEP;
      end
    end
  end

  // ==================================================
  // image refresh and sync supervision
  reg  sync_seen;
  wire refresh = distributed_clock_sync ? sync_pulse : cycle_strobe;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_seen           <= 1'b0;
      sync_fault_flag     <= `ECP_RST_BIT;
      input_update_toggle <= `ECP_RST_BIT;
      position_count      <= `ECP_RST_WORD;
      captured_count      <= `ECP_RST_WORD;
      measured_frequency  <= `ECP_RST_WORD;
      measured_period     <= `ECP_RST_WORD;
      last_change_time    <= `ECP_RST_TIME;
    end else begin
      // a sync pulse in the same cycle as the strobe still counts for this cycle
      if (cycle_strobe) begin
        sync_seen       <= 1'b0;
        sync_fault_flag <= distributed_clock_sync & ~(sync_seen | sync_pulse);
      end else if (sync_pulse) begin
        sync_seen <= 1'b1;
      end
      if (refresh) begin
        input_update_toggle <= ~input_update_toggle;
        position_count      <= count;
        captured_count      <= latch_val;
        measured_frequency  <= freq_val;
        measured_period     <= per_val;
        last_change_time    <= stamp;
      end
    end
  end

  // ==================================================
  // live levels
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      track_a_level       <= `ECP_RST_BIT;
      track_b_level       <= `ECP_RST_BIT;
      reference_level     <= `ECP_RST_BIT;
      external_gate_level <= `ECP_RST_BIT;
    end else begin
      track_a_level       <= level[0];
      track_b_level       <= level[1];
      reference_level     <= level[2];
      external_gate_level <= level[3];
    end
  end

  // ==================================================
  // identity objects, constant from reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      device_type_word  <= {MODULE_PROFILE, `ECP_PROFILE_NUMBER};
      identity_entries  <= `ECP_IDENTITY_ENTRIES;
      vendor_code       <= VENDOR_VALUE;
      product_code_word <= PRODUCT_VALUE;
      revision_word     <= {DESC_REVISION, VARIANT_NUMBER};
      serial_word       <= {`ECP_SER_UPPER, PROD_WEEK, PROD_YEAR};
    end else begin
      device_type_word  <= {MODULE_PROFILE, `ECP_PROFILE_NUMBER};
      identity_entries  <= `ECP_IDENTITY_ENTRIES;
      vendor_code       <= VENDOR_VALUE;
      product_code_word <= PRODUCT_VALUE;
      revision_word     <= {DESC_REVISION, VARIANT_NUMBER};
      serial_word       <= {`ECP_SER_UPPER, PROD_WEEK, PROD_YEAR};
    end
  end

endmodule // ecp_top

// ---- ecp_top_sva.sv ----
// checker for the encoder counter process image: refresh toggle, sync fault, preset, latch, track b level, identity
// assumes it is bound to ecp_top and sees only its ports
`timescale 1ns/100ps
module ecp_top_sva (
  // clock and reset
  input wire        clk, resetn,
  // fieldbus cycle and master bits
  input wire        cycle_strobe, distributed_clock_sync, sync_pulse, preset_load_command,
  input wire        reference_capture_enable, gate_rise_capture_enable, gate_fall_capture_enable,
  // pins and image
  input wire        track_b_pin, track_b_level, preset_done, reference_capture_valid, gate_capture_valid,
  input wire        sync_fault_flag, input_update_toggle,
  // identity
  input wire [31:0] device_type_word, serial_word,
  input wire [7:0]  identity_entries
);
  // ==========
  // refresh source follows the sync mode
  wire refresh = distributed_clock_sync ? sync_pulse : cycle_strobe;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_toggle_flip: assert property (refresh |=> input_update_toggle != $past(input_update_toggle))
    else $error("toggle did not invert on refresh");
  a_toggle_hold: assert property (!refresh |=> $stable(input_update_toggle))
    else $error("toggle moved without refresh");
  a_fault_plain: assert property (cycle_strobe && !distributed_clock_sync |=> !sync_fault_flag)
    else $error("sync fault outside sync mode");
  a_fault_paired: assert property (cycle_strobe && sync_pulse |=> !sync_fault_flag)
    else $error("sync fault despite sync pulse");
  a_preset_done: assert property ($rose(preset_load_command) |-> ##[1:2] preset_done)
    else $error("preset done missing");
  a_done_drop: assert property ($fell(preset_load_command) |-> ##[1:2] !preset_done)
    else $error("preset done stuck");
  a_ref_cause: assert property ($rose(reference_capture_valid) |-> $past(reference_capture_enable))
    else $error("reference capture while disabled");
  a_gate_cause: assert property ($rose(gate_capture_valid) |-> $past(gate_rise_capture_enable) ||
    $past(gate_fall_capture_enable))
    else $error("gate capture while disabled");
  a_ref_clear: assert property (!reference_capture_enable [*3] |-> !reference_capture_valid)
    else $error("reference valid not cleared");
  a_b_level: assert property ($stable(track_b_pin) [*7] |-> track_b_level == track_b_pin)
    else $error("track b level wrong");
  a_identity_fixed: assert property (device_type_word[15:0] == 16'h1389 && identity_entries == 8'h04 &&
    serial_word[31:16] == 16'h0000)
    else $error("identity field wrong");

  c_refresh: cover property (refresh ##1 refresh);
  c_ref_latch: cover property ($rose(reference_capture_valid));
  c_preset: cover property ($rose(preset_done));
endmodule // ecp_top_sva

bind ecp_top ecp_top_sva sva_u (.clk, .resetn, .cycle_strobe, .distributed_clock_sync, .sync_pulse,
  .preset_load_command, .reference_capture_enable, .gate_rise_capture_enable, .gate_fall_capture_enable,
  .track_b_pin, .track_b_level, .preset_done, .reference_capture_valid, .gate_capture_valid,
  .sync_fault_flag, .input_update_toggle, .device_type_word, .serial_word, .identity_entries);

// ---- ecp_enc_model.sv ----
// encoder, reference and gate pin model facing ecp_top
// assumes the bench calls its tasks from one process
`timescale 1ns/100ps
module ecp_enc_model (
  // clock
  input  wire clk,
  // pins
  output reg  track_a_pin,
  output reg  track_b_pin,
  output reg  reference_pin,
  output reg  external_gate_pin
);
  reg [1:0] phase;
  initial begin
    phase = 2'h0;
    track_a_pin = 1'b0;
    track_b_pin = 1'b0;
    reference_pin = 1'b0;
    external_gate_pin = 1'b0;
  end
  // ==========
  // a leads b when counting up; each level held well past the input filter
  task automatic step(input bit up, input int hold);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    @(posedge clk);
    track_a_pin <= phase[1] ^ phase[0];
    track_b_pin <= phase[1];
    repeat (hold) @(posedge clk);
  endtask
  task automatic set_pin(input bit gate, input bit v);
    @(posedge clk);
    if (gate)
      external_gate_pin <= v;
    else
      reference_pin <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule // ecp_enc_model

// ---- tb_ecp_top.sv ----
// self-checking bench for ecp_top with a pin model on the encoder side
// assumes ecp_enc_model and the bound checker are compiled with it
`timescale 1ns/100ps
module tb_ecp_top;
  // identity values are arbitrary
  localparam [15:0] MOD_PROF = 16'h0042;
  localparam [31:0] VEND     = 32'h00005a5a;
  localparam [31:0] PROD     = 32'h00000777;
  localparam [15:0] VARIANT  = 16'h0003;
  localparam [15:0] DESC     = 16'h0005;
  localparam [7:0]  YEAR     = 8'h19;
  localparam [7:0]  WEEK     = 8'h07;
  reg         clk = 1'b0, resetn = 1'b0;
  reg         cycle_strobe = 1'b0, distributed_clock_sync = 1'b0, sync_pulse = 1'b0;
  reg         reference_capture_enable = 1'b0, gate_rise_capture_enable = 1'b0, gate_fall_capture_enable = 1'b0;
  reg         preset_load_command = 1'b0, reference_reset_enable = 1'b0, gate_reset_enable = 1'b0;
  reg  [31:0] preset_value = 32'h00000000;
  wire        track_a_pin, track_b_pin, reference_pin, external_gate_pin;
  wire        reference_capture_valid, gate_capture_valid, preset_done, track_a_level, track_b_level;
  wire        reference_level, external_gate_level, sync_fault_flag, input_update_toggle;
  wire [31:0] position_count, captured_count, measured_frequency, measured_period;
  wire [63:0] last_change_time;
  wire [31:0] device_type_word, vendor_code, product_code_word, revision_word, serial_word;
  wire [7:0]  identity_entries;
  reg  [31:0] cnt = 32'h00000000;
  reg  [31:0] cap;
  reg  [63:0] stamp;
  int         fail_count = 0;
  int         checked = 0;

  ecp_top #(.FREQ_WINDOW_CYC(100), .MODULE_PROFILE(MOD_PROF), .VENDOR_VALUE(VEND), .PRODUCT_VALUE(PROD),
    .VARIANT_NUMBER(VARIANT), .DESC_REVISION(DESC), .PROD_YEAR(YEAR), .PROD_WEEK(WEEK)) dut_u (
    .clk, .resetn, .track_a_pin, .track_b_pin, .reference_pin, .external_gate_pin, .cycle_strobe,
    .distributed_clock_sync, .sync_pulse, .reference_capture_enable, .gate_rise_capture_enable,
    .preset_load_command, .gate_fall_capture_enable, .preset_value, .reference_reset_enable,
    .gate_reset_enable, .reference_capture_valid, .gate_capture_valid, .preset_done, .track_a_level,
    .track_b_level, .reference_level, .external_gate_level, .sync_fault_flag, .input_update_toggle,
    .position_count, .captured_count, .measured_frequency, .measured_period, .last_change_time,
    .device_type_word, .identity_entries, .vendor_code, .product_code_word, .revision_word, .serial_word);
  ecp_enc_model enc_u (.clk, .track_a_pin, .track_b_pin, .reference_pin, .external_gate_pin);

  always #2 clk = ~clk;

  // ==========
  // shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic mv(input bit up, input int n, input int hold);
    repeat (n) begin
      enc_u.step(up, hold);
      cnt = up ? cnt + 32'h1 : cnt - 32'h1;
    end
  endtask
  // image only moves on the active refresh source, so the toggle is judged here every time
  task automatic refresh(input bit sp, input bit cs);
    logic old;
    old = input_update_toggle;
    @(posedge clk);
    sync_pulse <= sp;
    cycle_strobe <= cs;
    @(posedge clk);
    sync_pulse <= 1'b0;
    cycle_strobe <= 1'b0;
    tick(1);
    chk(input_update_toggle, old ^ (distributed_clock_sync ? sp : cs));
  endtask
  task automatic pulse(input bit gate);
    enc_u.set_pin(gate, 1'b1);
    enc_u.set_pin(gate, 1'b0);
  endtask

  // ==========
  // scenarios
  task automatic t_ident;
    chk(device_type_word, {MOD_PROF, 16'h1389});
    chk({vendor_code, product_code_word}, {VEND, PROD});
    chk(revision_word, {DESC, VARIANT});
    chk(serial_word, {16'h0000, WEEK, YEAR});
    chk(identity_entries, 8'h04);
    $display("identity test done");
  endtask
  task automatic t_count;
    mv(1, 9, 6);
    refresh(0, 1);
    chk(position_count, cnt);
    stamp = last_change_time;
    mv(0, 2, 6);
    refresh(0, 1);
    chk(position_count, cnt);
    chk(last_change_time > stamp, 1'b1);
    enc_u.set_pin(0, 1'b1);
    enc_u.set_pin(1, 1'b1);
    tick(0);
    chk({reference_level, external_gate_level, track_b_level, track_a_level}, {2'h3, track_b_pin, track_a_pin});
    enc_u.set_pin(0, 1'b0);
    enc_u.set_pin(1, 1'b0);
    tick(0);
    chk({reference_level, external_gate_level}, 2'h0);
    $display("count test done");
  endtask
  task automatic t_preset;
    @(posedge clk);
    preset_value <= 32'hfffffffe;
    preset_load_command <= 1'b1;
    for (int n = 0; preset_done !== 1'b1; n++) begin
      if (n == 10) begin
        fail_count++;
        wrap_up;
      end
      tick(1);
    end
    cnt = 32'hfffffffe;
    refresh(0, 1);
    chk(position_count, 32'hfffffffe);
    mv(1, 3, 6);
    refresh(0, 1);
    chk({preset_done, position_count}, {1'b1, 32'h00000001});
    @(posedge clk);
    preset_load_command <= 1'b0;
    tick(3);
    chk(preset_done, 1'b0);
    $display("preset test done");
  endtask
  task automatic t_latch;
    @(posedge clk);
    reference_capture_enable <= 1'b1;
    tick(2);
    cap = cnt;
    pulse(0);
    mv(1, 2, 6);
    pulse(0);
    refresh(0, 1);
    chk({reference_capture_valid, captured_count}, {1'b1, cap});
    @(posedge clk);
    reference_capture_enable <= 1'b0;
    gate_rise_capture_enable <= 1'b1;
    tick(3);
    chk(reference_capture_valid, 1'b0);
    cap = cnt;
    enc_u.set_pin(1, 1'b1);
    mv(1, 1, 6);
    enc_u.set_pin(1, 1'b0);
    refresh(0, 1);
    chk({gate_capture_valid, captured_count}, {1'b1, cap});
    @(posedge clk);
    gate_fall_capture_enable <= 1'b1;
    gate_rise_capture_enable <= 1'b0;
    tick(3);
    enc_u.set_pin(1, 1'b1);
    cap = cnt;
    enc_u.set_pin(1, 1'b0);
    mv(0, 1, 6);
    refresh(0, 1);
    chk(captured_count, cap);
    @(posedge clk);
    gate_fall_capture_enable <= 1'b0;
    $display("latch test done");
  endtask
  task automatic t_clear;
    @(posedge clk);
    reference_reset_enable <= 1'b1;
    gate_reset_enable <= 1'b1;
    pulse(0);
    refresh(0, 1);
    chk(position_count, cnt);
    @(posedge clk);
    gate_reset_enable <= 1'b0;
    pulse(0);
    refresh(0, 1);
    chk(position_count, 32'h00000000);
    cnt = 32'h00000000;
    @(posedge clk);
    reference_reset_enable <= 1'b0;
    $display("clear test done");
  endtask
  task automatic t_sync_rate;
    @(posedge clk);
    distributed_clock_sync <= 1'b1;
    tick(1);
    refresh(1, 1);
    chk(sync_fault_flag, 1'b0);
    refresh(0, 1);
    chk(sync_fault_flag, 1'b1);
    refresh(1, 0);
    @(posedge clk);
    distributed_clock_sync <= 1'b0;
    // 25 clocks a step gives a track a period of 100 clocks, 400 ns: one rise in every 100-clock window
    mv(1, 12, 24);
    refresh(0, 1);
    chk(measured_period, 32'h00000004);
    chk(measured_frequency, 32'h00002710);
    $display("sync and rate test done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    t_ident;
    t_count;
    t_preset;
    t_latch;
    t_clear;
    t_sync_rate;
    wrap_up;
  end
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
endmodule // tb_ecp_top
